/* aicd_pkg.sv */
package aicd_pkg;

   // register byte offsets on the ahb-lite slave
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic [7:0]  ADDR_RESULT  = 8'h08;
   localparam logic [7:0]  ADDR_LIVE    = 8'h0c;

   // status register bit positions
   localparam int ST_ACQ_READY  = 0;
   localparam int ST_MODE_LSB   = 1;
   localparam int ST_SPAN2X     = 3;
   localparam int ST_TWOS       = 4;
   localparam int ST_CORRUPT    = 5;
   localparam int ST_RES_VALID  = 6;
   localparam int ST_ACQ_SHORT  = 7;
   localparam int ST_CFG_VALID  = 8;

   // acquisition time and its clock count (least time, rounded up)
   localparam int CLK_PERIOD_NS = 8;
   localparam int ACQ_TIME_NS   = 90;
   localparam int ACQ_CYCLES    =
      (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] ACQ_CYCLES_RST = 16'(ACQ_CYCLES);

   // serial clock edge counts within one conversion
   localparam logic [4:0]  TRACK_RISE_EDGE  = 5'h0d;
   localparam logic [4:0]  RESULT_FALL_EDGE = 5'h0e;
   localparam logic [4:0]  RANGE_FREE_FALL  = 5'h03;

   // selector code for the analog ground return
   localparam logic [2:0]  SEL_GND = 3'h0;

   typedef enum logic [1:0] {
      MODE_SGL    = 2'b00,
      MODE_FULL   = 2'b01,
      MODE_PSEUDO = 2'b10,
      MODE_UNDEF  = 2'b11
   } aicd_mode_t;

   typedef enum logic [1:0] {
      ST_TRACK = 2'b00,
      ST_HOLD  = 2'b01,
      ST_READ  = 2'b10
   } aicd_state_t;

   typedef struct packed {
      aicd_mode_t mode;
      logic [2:0] pos;
      logic [2:0] neg;
      logic       span2x;
      logic       twos;
      logic       valid;
   } aicd_cfg_t;

   // straight binary core code to the chosen output coding
   function automatic logic [11:0] aicd_recode(input logic [11:0] raw,
                                               input logic        twos);
      aicd_recode = twos ? {~raw[11], raw[10:0]} : raw;
   endfunction

endpackage

/* aicd_decode.sv */
`timescale 1ns/1ps
module aicd_decode
   import aicd_pkg::*;
(
   input  wire logic       type_sel_in,
   input  wire logic [2:0] addr_in,
   input  wire logic       range_in,
   output aicd_cfg_t       cfg_out
);

   logic [2:0] base;

   // pin levels to input selection, mode and coding
   always_comb begin
      base           = {addr_in[2:1], 1'b0};
      cfg_out        = '0;
      cfg_out.span2x = range_in;
      if (type_sel_in) begin
         cfg_out.mode  = MODE_SGL;
         cfg_out.pos   = 3'(addr_in + 3'h1);
         cfg_out.neg   = SEL_GND;
         cfg_out.valid = (addr_in <= 3'h5);
      end else begin
         cfg_out.pos   = 3'(base + 3'h1);
         cfg_out.neg   = 3'(base + 3'h2);
         cfg_out.mode  = addr_in[0] ? MODE_PSEUDO : MODE_FULL;
         cfg_out.valid = (addr_in[2:1] != 2'b11);
      end
      cfg_out.twos = (cfg_out.mode == MODE_FULL) | range_in;
   end

endmodule

/* aicd_core.sv */
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module aicd_core
   import aicd_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   input  wire logic        ce_in,
   input  wire logic        input_type_select_in,
   input  wire logic [2:0]  channel_address_in,
   input  wire logic        range_in,
   input  wire logic        conv_select_n_in,
   input  wire logic        sclk_in,
   input  wire logic [11:0] raw_sample_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic      [2:0]  conv_a_pos_sel_out,
   output logic      [2:0]  conv_a_neg_sel_out,
   output logic      [2:0]  conv_b_pos_sel_out,
   output logic      [2:0]  conv_b_neg_sel_out,
   output logic             span_2x_out,
   output logic             tracking_out,
   output logic      [11:0] result_out,
   output logic             result_valid_out
);

   logic [6:0]  sync1_reg;
   logic [6:0]  sync2_reg;
   logic [6:0]  sync3_reg;
   logic [6:0]  pin_reg;
   logic [6:0]  pin_next;
   logic [6:0]  agree;
   logic        type_q;
   logic [2:0]  addr_q;
   logic        range_q;
   logic        cs_fall;
   logic        cs_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        type_chg;
   logic        range_chg;
   logic        mode_chg;
   aicd_cfg_t   live_cfg;
   aicd_cfg_t   lat_reg;
   aicd_state_t state_reg;
   logic [4:0]  rise_cnt_reg;
   logic [4:0]  fall_cnt_reg;
   logic [15:0] acq_cnt_reg;
   logic [15:0] acq_cycles_reg;
   logic        acq_ready;
   logic        res_load;
   logic        corrupt_reg;
   logic        acq_short_reg;
   logic        wr_pend_reg;
   logic        rd_sel;
   logic        w1c_corrupt;
   logic        w1c_valid;
   logic        w1c_short;
   logic [7:0]  wr_addr_reg;
   logic [31:0] status_word;
   logic [31:0] rd_word;

   // three-stage synchronisers for the host pins
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         sync1_reg <= 7'h03;
         sync2_reg <= 7'h03;
         sync3_reg <= 7'h03;
         pin_reg   <= 7'h03;
      end else if (ce_in) begin
         sync1_reg <= {input_type_select_in, channel_address_in, range_in,
                       conv_select_n_in, sclk_in};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg   <= pin_next;
      end
   end

   // a change counts once stages two and three agree
   assign agree    = ~(sync2_reg ^ sync3_reg);
   assign pin_next = (agree & sync3_reg) | (~agree & pin_reg);
   assign type_q   = pin_next[6];
   assign addr_q   = pin_next[5:3];
   assign range_q  = pin_next[2];
   assign cs_fall  = pin_reg[1] & ~pin_next[1];
   assign cs_rise  = ~pin_reg[1] & pin_next[1];
   assign sclk_rise = ~pin_reg[0] & pin_next[0];
   assign sclk_fall = pin_reg[0] & ~pin_next[0];
   assign type_chg  = pin_reg[6] ^ pin_next[6];
   assign range_chg = pin_reg[2] ^ pin_next[2];

   aicd_decode u_decode (
      .type_sel_in (type_q),
      .addr_in     (addr_q),
      .range_in    (range_q),
      .cfg_out     (live_cfg)
   );

   // live mode compared with the mode of the previous stable pins
   assign mode_chg = type_chg |
                     (~pin_reg[6] & ~type_q & (pin_reg[3] ^ addr_q[0]));

   // conversion sequencer driven by select and serial clock edges
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_reg    <= ST_TRACK;
         rise_cnt_reg <= 5'h00;
         fall_cnt_reg <= 5'h00;
         lat_reg      <= '0;
      end else if (ce_in) begin
         if (cs_rise) begin
            state_reg <= ST_TRACK;
         end else if (cs_fall) begin
            state_reg    <= ST_HOLD;
            rise_cnt_reg <= 5'h00;
            fall_cnt_reg <= 5'h00;
            lat_reg      <= live_cfg;
         end else begin
            if (sclk_rise && state_reg == ST_HOLD) begin
               rise_cnt_reg <= 5'(rise_cnt_reg + 5'h01);
               if (5'(rise_cnt_reg + 5'h01) == TRACK_RISE_EDGE) begin
                  state_reg <= ST_READ;
               end
            end
            if (sclk_fall && state_reg != ST_TRACK &&
                fall_cnt_reg != RESULT_FALL_EDGE) begin
               fall_cnt_reg <= 5'(fall_cnt_reg + 5'h01);
            end
         end
      end
   end

   // result is taken on the fourteenth serial clock fall
   assign res_load = sclk_fall && state_reg != ST_TRACK && !cs_rise &&
                     5'(fall_cnt_reg + 5'h01) == RESULT_FALL_EDGE;

   // acquisition timer restarts on mode change and on the thirteenth serial clock rise in hold
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         acq_cnt_reg <= 16'h0000;
      end else if (ce_in) begin
         if (mode_chg ||
             (sclk_rise && state_reg == ST_HOLD &&
              5'(rise_cnt_reg + 5'h01) == TRACK_RISE_EDGE)) begin
            acq_cnt_reg <= 16'h0000;
         end else if (!acq_ready) begin
            acq_cnt_reg <= 16'(acq_cnt_reg + 16'h0001);
         end
      end
   end
   assign acq_ready = (acq_cnt_reg >= acq_cycles_reg);

   // selections and span follow the stable pins whenever ce_in is high
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         conv_a_pos_sel_out <= 3'h0;
         conv_a_neg_sel_out <= 3'h0;
         conv_b_pos_sel_out <= 3'h0;
         conv_b_neg_sel_out <= 3'h0;
         span_2x_out        <= 1'b0;
         tracking_out       <= 1'b1;
      end else if (ce_in) begin
         conv_a_pos_sel_out <= live_cfg.pos;
         conv_a_neg_sel_out <= live_cfg.neg;
         conv_b_pos_sel_out <= live_cfg.pos;
         conv_b_neg_sel_out <= live_cfg.neg;
         span_2x_out        <= range_q;
         tracking_out       <= (state_reg != ST_HOLD) && !cs_fall;
      end
   end

   // result in the coding latched for this conversion
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         result_out <= 12'h000;
      end else if (ce_in && res_load) begin
         result_out <= aicd_recode(raw_sample_in, lat_reg.twos);
      end
   end

   // sticky flags, a new event wins over a software clear
   assign w1c_corrupt = wr_pend_reg && wr_addr_reg == ADDR_STATUS &&
                        hwdata_in[ST_CORRUPT];
   assign w1c_valid   = wr_pend_reg && wr_addr_reg == ADDR_STATUS &&
                        hwdata_in[ST_RES_VALID];
   assign w1c_short   = wr_pend_reg && wr_addr_reg == ADDR_STATUS &&
                        hwdata_in[ST_ACQ_SHORT];
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         corrupt_reg      <= 1'b0;
         acq_short_reg    <= 1'b0;
         result_valid_out <= 1'b0;
      end else if (ce_in) begin
         if ((state_reg == ST_HOLD && type_chg) ||
             (state_reg == ST_HOLD && range_chg &&
              fall_cnt_reg < RANGE_FREE_FALL)) begin
            corrupt_reg <= 1'b1;
         end else if (cs_fall) begin
            corrupt_reg <= 1'b0;
         end else if (w1c_corrupt) begin
            corrupt_reg <= 1'b0;
         end
         if (cs_fall && !acq_ready) begin
            acq_short_reg <= 1'b1;
         end else if (w1c_short) begin
            acq_short_reg <= 1'b0;
         end
         if (res_load) begin
            result_valid_out <= 1'b1;
         end else if (w1c_valid || cs_fall) begin
            result_valid_out <= 1'b0;
         end
      end
   end

   // status word and read mux
   always_comb begin
      status_word                 = 32'h0000_0000;
      status_word[ST_ACQ_READY]   = acq_ready;
      status_word[ST_MODE_LSB+:2] = lat_reg.mode;
      status_word[ST_SPAN2X]      = lat_reg.span2x;
      status_word[ST_TWOS]        = lat_reg.twos;
      status_word[ST_CORRUPT]     = corrupt_reg;
      status_word[ST_RES_VALID]   = result_valid_out;
      status_word[ST_ACQ_SHORT]   = acq_short_reg;
      status_word[ST_CFG_VALID]   = lat_reg.valid;
      case (haddr_in[7:0])
         ADDR_CTRL:   rd_word = {16'h0000, acq_cycles_reg};
         ADDR_STATUS: rd_word = status_word;
         ADDR_RESULT: rd_word = {20'h00000, result_out};
         ADDR_LIVE:   rd_word = {21'h000000, live_cfg};
         default:     rd_word = 32'h0000_0000;
      endcase
   end

   assign rd_sel = hsel_in && hready_in && htrans_in[1] && !hwrite_in;

   // ahb-lite slave, zero wait states, always okay
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         hrdata_out     <= 32'h0000_0000;
         hreadyout_out  <= 1'b1;
         hresp_out      <= 1'b0;
         wr_pend_reg    <= 1'b0;
         wr_addr_reg    <= 8'h00;
         acq_cycles_reg <= ACQ_CYCLES_RST;
      end else if (ce_in) begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         wr_pend_reg   <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
         wr_addr_reg   <= haddr_in[7:0];
         if (rd_sel) begin
            hrdata_out <= (haddr_in[31:8] == 24'h000000) ? rd_word
                                                         : 32'h0000_0000;
         end
         if (wr_pend_reg && wr_addr_reg == ADDR_CTRL) begin
            acq_cycles_reg <= hwdata_in[15:0];
         end
      end
   end

   // checks on decode, sequencing and coding
   a_cs_latch_cfg: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && cs_fall && !cs_rise |=> lat_reg == $past(live_cfg))
      else $error("config not latched at select fall");
   a_track_return: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && !cs_rise && !cs_fall && sclk_rise && state_reg == ST_HOLD &&
      rise_cnt_reg == 5'h0c |=> state_reg == ST_READ && rise_cnt_reg == 5'h0d)
      else $error("no return to track on 13th rise");
   a_mode_restart: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && mode_chg |=> acq_cnt_reg == 16'h0000)
      else $error("mode change did not restart acquisition");
   a_sgl_ground: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && type_q |=> conv_a_neg_sel_out == SEL_GND &&
      conv_b_neg_sel_out == SEL_GND)
      else $error("single ended input not on ground");
   a_diff_pair: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && !type_q && addr_q[2:1] != 2'b11 |=>
      conv_a_pos_sel_out == {$past(addr_q[2:1]), 1'b1} &&
      conv_a_neg_sel_out == 3'(conv_a_pos_sel_out + 3'h1))
      else $error("wrong differential pair");
   a_sgl_index: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && type_q && addr_q <= 3'h5 |=>
      conv_b_pos_sel_out == 3'($past(addr_q) + 3'h1) &&
      conv_a_pos_sel_out == conv_b_pos_sel_out)
      else $error("wrong single ended input");
   a_span_follow: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in |=> span_2x_out == $past(range_q))
      else $error("span does not follow range");
   a_result_coding: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      ce_in && res_load |=> result_valid_out &&
      result_out == aicd_recode($past(raw_sample_in), $past(lat_reg.twos)))
      else $error("result not in latched coding");
   a_twos_choice: assert property (@(posedge mclk_in)
      disable iff (!resetn_in)
      live_cfg.twos == ((!type_q && !addr_q[0]) || range_q))
      else $error("wrong coding choice");

endmodule

/* aicd_host_model.sv */
`timescale 1ns/1ps
// host side: configuration pins, conversion select and serial clock
module aicd_host_model (
   input  wire logic       mclk_in,
   output logic            type_sel_out,
   output logic      [2:0] addr_out,
   output logic            range_out,
   output logic            cs_n_out,
   output logic            sclk_out
);
   // idle: select high, serial clock parked high between frames
   initial begin
      type_sel_out = 1'b0;
      addr_out     = 3'h0;
      range_out    = 1'b0;
      cs_n_out     = 1'b1;
      sclk_out     = 1'b1;
   end
   // pins move together, then w cycles pass for sync and acquisition
   task automatic set_pins(input logic t, input logic [2:0] a,
                           input logic r, input int w);
      @(posedge mclk_in);
      type_sel_out <= t;
      addr_out     <= a;
      range_out    <= r;
      repeat (w) @(posedge mclk_in);
   endtask
   // one frame of n serial clocks; range moves after the fourth fall,
   // flip upsets the type pin inside the hold on purpose
   task automatic convert(input int n, input logic r_late, input logic flip);
      @(posedge mclk_in);
      cs_n_out <= 1'b0;
      repeat (4) @(posedge mclk_in);
      for (int i = 1; i <= n; i++) begin
         sclk_out <= 1'b0;
         repeat (4) @(posedge mclk_in);
         sclk_out <= 1'b1;
         if (i == 4) range_out <= r_late;
         if (i == 5 && flip) type_sel_out <= ~type_sel_out;
         repeat (4) @(posedge mclk_in);
      end
      cs_n_out <= 1'b1;
      repeat (8) @(posedge mclk_in);
   endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`define chk_eq(a, e) \
   begin \
      checks++; \
      if ((a) !== (e)) begin \
         n_mismatch++; \
         $display("unexpected at %0t: got %h expected %h", $time, a, e); \
      end \
   end
module testbench
   import aicd_pkg::*;
;
   logic        mclk, resetn, hsel, hwrite, hready, hresp;
   logic        span2x, tracking, rvalid, tsel, rng, cs_n, sclk;
   logic        t_e, r_e, twos_e, ce;
   logic [1:0]  htrans, mode_e;
   logic [2:0]  hsize, a_pos, a_neg, b_pos, b_neg, addr, a_e, pos_e, neg_e;
   logic [11:0] raw, result, v, exp_res;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          n_mismatch, checks;

   // free running 125 MHz clock
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   aicd_host_model host (.mclk_in(mclk), .type_sel_out(tsel),
      .addr_out(addr), .range_out(rng), .cs_n_out(cs_n), .sclk_out(sclk));

   aicd_core DUT (.mclk_in(mclk), .resetn_in(resetn), .ce_in(ce),
      .input_type_select_in(tsel), .channel_address_in(addr),
      .range_in(rng), .conv_select_n_in(cs_n), .sclk_in(sclk),
      .raw_sample_in(raw), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp),
      .conv_a_pos_sel_out(a_pos), .conv_a_neg_sel_out(a_neg),
      .conv_b_pos_sel_out(b_pos), .conv_b_neg_sel_out(b_neg),
      .span_2x_out(span2x), .tracking_out(tracking),
      .result_out(result), .result_valid_out(rvalid));

   // verdict and end of run
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // bounded wait for ready sampled high at a rising edge
   task automatic wait_ready();
      int i;
      i = 0;
      @(posedge mclk);
      while (hready !== 1'b1 && i < 50) begin
         @(posedge mclk);
         i++;
      end
      if (hready !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask

   // one single word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'h2;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      d = hrdata;
   endtask

   // main sequence
   initial begin
      resetn = 1'b0;
      ce     = 1'b1;
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
      raw    = 12'h000;
      n_mismatch = 0;
      checks = 0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      `chk_eq(hrdata, 32'h0)
      // register block, including an unmapped word
      ahb(1'b0, ADDR_CTRL, 32'h0, rd);
      `chk_eq(rd, {16'h0, ACQ_CYCLES_RST})
      ahb(1'b1, ADDR_CTRL, 32'h14, rd);
      ahb(1'b0, ADDR_CTRL, 32'h0, rd);
      `chk_eq(rd, 32'h14)
      ahb(1'b1, ADDR_CTRL, {16'h0, ACQ_CYCLES_RST}, rd);
      ahb(1'b1, 8'h10, 32'hffffffff, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      `chk_eq(rd, 32'h0)
      // both types, addresses 0 to 5 and both ranges, each with a full conversion
      for (int k = 0; k < 24; k++) begin
         t_e = (k < 12);
         a_e = 3'((k % 12) / 2);
         r_e = k[0];
         mode_e = t_e ? MODE_SGL : (a_e[0] ? MODE_PSEUDO : MODE_FULL);
         pos_e = t_e ? 3'(a_e + 3'h1) : {a_e[2:1], 1'b1};
         neg_e = t_e ? 3'h0 : 3'(pos_e + 3'h1);
         twos_e = (mode_e == MODE_FULL) | r_e;
         v = 12'(32'h0a5 + k * 32'h1d3);
         exp_res = twos_e ? {~v[11], v[10:0]} : v;
         raw <= v;
         host.set_pins(t_e, a_e, r_e, 24);
         `chk_eq(a_pos, pos_e)
         `chk_eq(a_neg, neg_e)
         `chk_eq(b_pos, pos_e)
         `chk_eq(b_neg, neg_e)
         `chk_eq(span2x, r_e)
         fork
            host.convert(14, ~r_e, 1'b0);
            begin
               repeat (40) @(posedge mclk);
               `chk_eq(tracking, 1'b0)
            end
         join
         `chk_eq(tracking, 1'b1)
         `chk_eq(result, exp_res)
         `chk_eq(rvalid, 1'b1)
         ahb(1'b0, ADDR_STATUS, 32'h0, rd);
         `chk_eq(rd[8:1], {4'b1010, twos_e, r_e, mode_e})
         ahb(1'b0, ADDR_RESULT, 32'h0, rd);
         `chk_eq(rd, {20'h0, exp_res})
      end
      // address moves: same mode keeps acquisition, new mode restarts it
      host.set_pins(1'b0, 3'h0, 1'b0, 30);
      host.set_pins(1'b0, 3'h2, 1'b0, 6);
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      `chk_eq(rd[ST_ACQ_READY], 1'b1)
      host.set_pins(1'b0, 3'h3, 1'b0, 4);
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      `chk_eq(rd[ST_ACQ_READY], 1'b0)
      repeat (20) @(posedge mclk);
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      `chk_eq(rd[ST_ACQ_READY], 1'b1)
      // frame cut short after ten clocks leaves no new result
      host.convert(10, 1'b0, 1'b0);
      `chk_eq(rvalid, 1'b0)
      `chk_eq(result, exp_res)
      // type pin upset during hold, then flags cleared by writing ones
      host.set_pins(1'b0, 3'h3, 1'b0, 24);
      host.convert(14, 1'b0, 1'b1);
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      `chk_eq(rd[ST_CORRUPT], 1'b1)
      ahb(1'b1, ADDR_STATUS, 32'h60, rd);
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      `chk_eq(rd[6:5], 2'b00)
      `chk_eq(rvalid, 1'b0)
      // undefined pair code right after a mode change: short acquisition
      host.set_pins(1'b0, 3'h7, 1'b1, 2);
      host.convert(14, 1'b1, 1'b0);
      `chk_eq(result, {~v[11], v[10:0]})
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      `chk_eq(rd[8:1], 8'h6e)
      `chk_eq(hresp, 1'b0)
      ahb(1'b0, ADDR_LIVE, 32'h0, rd);
      `chk_eq(rd, 32'h5c6)
      // clock enable low freezes the selections until it returns
      ce <= 1'b0;
      host.set_pins(1'b1, 3'h2, 1'b0, 8);
      `chk_eq(a_pos, 3'h7)
      `chk_eq(span2x, 1'b1)
      ce <= 1'b1;
      repeat (6) @(posedge mclk);
      `chk_eq(a_pos, 3'h3)
      `chk_eq(span2x, 1'b0)
      finish_test();
   end
endmodule
